//--- rtl/vfid_pkg.sv
// Purpose: Constants for the vector feature identification register block.
// Assumes: Single core clock, synchronous active-high reset.
// Notes: Field layout, values, access encoding and trap codes live here.
package vfid_pkg;
	localparam int REG_W = 64;
	localparam int FLD_W = 4;
	localparam int INT8_MATMUL_FIELD_LSB = 44;
	localparam int SM4_LSB = 40;
	localparam int SHA3_LSB = 32;
	localparam int BFLOAT_SUPPORT_FIELD_LSB = 20;
	localparam int BPERM_LSB = 16;
	localparam int CIPH_LSB = 4;
	localparam int VER_LSB = 0;
	localparam logic [3:0] FLD_NONE = 4'h0;
	localparam logic [3:0] FLD_ONE = 4'h1;
	localparam logic [3:0] FLD_CIPH_ON = 4'h2;
	localparam logic [1:0] OP0_SEL = 2'h3;
	localparam logic [2:0] OP1_SEL = 3'h0;
	localparam logic [3:0] CRN_SEL = 4'h0;
	localparam logic [3:0] CRM_SEL = 4'h4;
	localparam logic [2:0] OP2_SEL = 3'h4;
	localparam logic [5:0] TRAP_CLASS = 6'h18;
	localparam logic [REG_W-1:0] ZERO64 = 64'h0000_0000_0000_0000;
	typedef enum logic [1:0] {
		LVL_USER,
		LVL_OS,
		LVL_HYP,
		LVL_MON
	} level_e;
endpackage

//--- rtl/sync3.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Asynchronous level input.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/100ps
module sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Data
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic dout_r;
	wire agree = (s2_r == s3_r);
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout_r <= 1'b0;
		end else if (ce) begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				dout_r <= s3_r;
			end
		end
	end
	assign dout = dout_r;
endmodule

//--- rtl/feature_field.sv
// Purpose: One four-bit feature field chosen by the build_param_a state.
// Assumes: Values are constants.
// Notes: Used for the SM4, SHA3 and cipher fields of the register.
`timescale 1ns/100ps
module feature_field #(
	parameter logic [3:0] OFF_VAL = 4'h0,
	parameter logic [3:0] ON_VAL = 4'h1
) (
	// Select
	input wire logic build_param_a_on,
	// Field
	output logic [3:0] fld
);
	assign fld = build_param_a_on ? ON_VAL : OFF_VAL;
endmodule

//--- rtl/vector_feature_id.sv
// Purpose: Read-only vector feature identification register with access checks.
// Assumes: Read requests arrive as one-cycle pulses on the core clock.
// Notes: Build_param_a option is latched at reset from a pin; fields are constant otherwise.
`timescale 1ns/100ps
module vector_feature_id #(
	parameter bit build_param_a = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Option straps
	input wire logic build_param_a_disable_input,
	// Read request
	input wire logic rd_req,
	input wire logic [1:0] rd_op0,
	input wire logic [2:0] rd_op1,
	input wire logic [3:0] rd_crn,
	input wire logic [3:0] rd_crm,
	input wire logic [2:0] rd_op2,
	input wire vfid_pkg::level_e rd_level,
	// Hypervisor state
	input wire logic hyp_enabled,
	input wire logic general_trap_control,
	input wire logic id_group3_trap_control,
	// Read answer
	output logic rd_valid,
	output logic [vfid_pkg::REG_W-1:0] rd_data,
	output logic rd_trap,
	output vfid_pkg::level_e rd_trap_level,
	output logic [5:0] rd_trap_class,
	output logic build_param_a_enabled
);
	import vfid_pkg::*;

	// ****************************************
	// Build_param_a option capture
	// ****************************************
	logic dis_sync;
	logic build_param_a_r;
	sync3 u_dis_sync (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.din(build_param_a_disable_input),
		.dout(dis_sync)
	);
	// The disable pin is resampled every cycle with ce high while reset is held, so the last sampled level wins.
	logic build_param_a_nxt;
	assign build_param_a_nxt = build_param_a & ~build_param_a_disable_input;
	always_ff @(posedge clk) begin
		if (ce && srst) begin
			build_param_a_r <= build_param_a_nxt;
		end
	end
	assign build_param_a_enabled = build_param_a_r;

	// ****************************************
	// Register image
	// ****************************************
	logic [3:0] sm4_f;
	logic [3:0] sha3_f;
	logic [3:0] ciph_f;
	feature_field #(.OFF_VAL(FLD_NONE), .ON_VAL(FLD_ONE)) u_sm4 (.build_param_a_on(build_param_a_r), .fld(sm4_f));
	feature_field #(.OFF_VAL(FLD_NONE), .ON_VAL(FLD_ONE)) u_sha3 (.build_param_a_on(build_param_a_r), .fld(sha3_f));
	feature_field #(.OFF_VAL(FLD_NONE), .ON_VAL(FLD_CIPH_ON)) u_ciph (.build_param_a_on(build_param_a_r), .fld(ciph_f));
	wire [REG_W-1:0] image = ZERO64
		| ({{(REG_W-FLD_W){1'b0}}, FLD_ONE} << INT8_MATMUL_FIELD_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, sm4_f} << SM4_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, sha3_f} << SHA3_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, FLD_ONE} << BFLOAT_SUPPORT_FIELD_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, FLD_ONE} << BPERM_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, ciph_f} << CIPH_LSB)
		| ({{(REG_W-FLD_W){1'b0}}, FLD_ONE} << VER_LSB);

	// ****************************************
	// Access check
	// ****************************************
	wire sel_hit = (rd_op0 == OP0_SEL) && (rd_op1 == OP1_SEL) && (rd_crn == CRN_SEL)
		&& (rd_crm == CRM_SEL) && (rd_op2 == OP2_SEL);
	wire is_user = (rd_level == LVL_USER);
	wire is_os = (rd_level == LVL_OS);
	wire user_to_hyp = hyp_enabled && general_trap_control;
	wire os_trap = is_os && hyp_enabled && id_group3_trap_control;
	wire trap_now = is_user || os_trap;
	wire level_e_hyp = (is_user && !user_to_hyp) ? 1'b0 : 1'b1;
	level_e trap_to;
	assign trap_to = level_e_hyp ? LVL_HYP : LVL_OS;

	// ****************************************
	// Answer registers
	// ****************************************
	logic valid_r;
	logic trap_r;
	level_e tlvl_r;
	logic [5:0] tcls_r;
	logic [REG_W-1:0] data_r;
	wire take = rd_req && sel_hit;
	always_ff @(posedge clk) begin
		if (srst) begin
			valid_r <= 1'b0;
			trap_r <= 1'b0;
			tlvl_r <= LVL_USER;
			tcls_r <= 6'h00;
			data_r <= ZERO64;
		end else if (ce) begin
			valid_r <= take;
			if (take) begin
				trap_r <= trap_now;
				tlvl_r <= trap_now ? trap_to : LVL_USER;
				tcls_r <= trap_now ? TRAP_CLASS : 6'h00;
				data_r <= trap_now ? ZERO64 : image;
			end
		end
	end
	assign rd_valid = valid_r;
	assign rd_trap = trap_r;
	assign rd_trap_level = tlvl_r;
	assign rd_trap_class = tcls_r;
	assign rd_data = data_r;
endmodule

//--- test/vfid_chk_assertions.sv
// Purpose: Port checks for vector_feature_id.
// Assumes: One clock, srst high resets.
// Notes: Bound into every instance.
`timescale 1ns/100ps
module vfid_chk import vfid_pkg::*; #(parameter bit build_param_a = 1'b1) (
	input wire logic clk, srst, ce, build_param_a_disable_input, rd_req,
	input wire logic [1:0] rd_op0,
	input wire logic [2:0] rd_op1, rd_op2,
	input wire logic [3:0] rd_crn, rd_crm,
	input wire vfid_pkg::level_e rd_level, rd_trap_level,
	input wire logic hyp_enabled, general_trap_control, id_group3_trap_control,
	input wire logic rd_valid, rd_trap, build_param_a_enabled,
	input wire logic [5:0] rd_trap_class,
	input wire logic [63:0] rd_data
);
	// Selector op0, op1, CRn, CRm, op2 packed into 16 bits.
	wire take = ce && rd_req && {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} == 16'hc024;
	wire [63:0] val = build_param_a_enabled ? 64'h0000_1101_0011_0021 : 64'h0000_1000_0011_0001;
	wire user = take && rd_level == LVL_USER;
	wire gt = hyp_enabled && general_trap_control;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_take; take; endsequence
	chk_read_answer: assert property (s_take |=> rd_valid) else $error("no answer");
	chk_no_stray: assert property (ce && !take |=> !rd_valid) else $error("stray answer");
	chk_user_hyp: assert property (user && gt |=> rd_trap && rd_trap_level == LVL_HYP &&
		rd_trap_class == 6'h18) else $error("user trap");
	chk_user_os: assert property (user && !gt |=> rd_trap && rd_trap_level == LVL_OS &&
		rd_data == ZERO64) else $error("user trap");
	chk_os_trap: assert property (take && rd_level == LVL_OS |=>
		rd_trap == ($past(hyp_enabled) && $past(id_group3_trap_control))) else $error("os trap");
	chk_high_read: assert property (take && rd_level inside {LVL_HYP, LVL_MON} |=> !rd_trap) else $error("trap");
	chk_value_map: assert property (rd_valid && !rd_trap |-> rd_data == val) else $error("value");
	chk_build_param_a_latch: assert property (!srst && $past(srst) && $past(ce) |->
		build_param_a_enabled == (build_param_a && !$past(build_param_a_disable_input))) else $error("latch");
endmodule
bind vector_feature_id vfid_chk #(.build_param_a(build_param_a)) chk (.*);

//--- test/sw_reader.sv
// Purpose: Software model issuing register reads.
// Assumes: Drives on falling edges.
// Notes: A wrong selector can be sent.
`timescale 1ns/100ps
module sw_reader (
	input wire logic clk,
	output logic rd_req,
	output logic [1:0] rd_op0,
	output logic [2:0] rd_op1, rd_op2,
	output logic [3:0] rd_crn, rd_crm,
	output vfid_pkg::level_e rd_level
);
	import vfid_pkg::*;
	initial begin
		{rd_req, rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} = {1'b0, 16'hc024};
		rd_level = LVL_USER;
	end
	task automatic rd(input level_e l, input bit good);
		@(negedge clk);
		rd_req = 1'b1;
		rd_level = l;
		rd_crm = good ? 4'h4 : 4'h5;
		@(negedge clk);
		rd_req = 1'b0;
		rd_crm = 4'hb;
	endtask
endmodule

//--- test/test_vector_feature_id.sv
// Purpose: Self-checking bench for vector_feature_id.
// Assumes: Answers come one cycle after a read.
// Notes: Build_param_a on and off are both reset in.
`timescale 1ns/100ps
module test_vector_feature_id;
	import vfid_pkg::*;
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, build_param_a_disable_input = 1'b0;
	logic hyp_enabled = 1'b0, general_trap_control = 1'b0, id_group3_trap_control = 1'b0;
	logic rd_req, rd_valid, rd_trap, build_param_a_enabled, tr;
	logic [1:0] rd_op0;
	logic [2:0] rd_op1, rd_op2;
	logic [3:0] rd_crn, rd_crm;
	logic [5:0] rd_trap_class;
	logic [63:0] rd_data;
	logic [73:0] e;
	level_e rd_level, rd_trap_level, tl;
	int err_total = 0, n_compared = 0;
	always #50 clk = ~clk;
	vector_feature_id uut (.*);
	sw_reader sw (.*);
	task automatic chk(input logic [73:0] got, input logic [73:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reset_with(input logic dis);
		@(negedge clk);
		build_param_a_disable_input = dis;
		srst = 1'b1;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		build_param_a_disable_input = ~dis;
	endtask
	task automatic read_chk(input level_e l, input logic [63:0] v);
		tr = l == LVL_USER || (l == LVL_OS && hyp_enabled && id_group3_trap_control);
		tl = (l == LVL_OS || (hyp_enabled && general_trap_control)) ? LVL_HYP : LVL_OS;
		e = tr ? {2'b11, tl, 6'h18, 64'h0} : {2'b10, LVL_USER, 6'h00, v};
		sw.rd(l, 1'b1);
		chk({rd_valid, rd_trap, rd_trap_level, rd_trap_class, rd_data}, e);
	endtask
	task automatic summarize;
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		reset_with(1'b0);
		chk(build_param_a_enabled, 1'b1);
		for (int i = 0; i < 32; i++) begin
			{hyp_enabled, general_trap_control, id_group3_trap_control} = i[2:0];
			read_chk(level_e'(i[4:3]), 64'h0000_1101_0011_0021);
		end
		sw.rd(LVL_MON, 1'b0);
		chk(rd_valid, 1'b0);
		ce = 1'b0;
		sw.rd(LVL_HYP, 1'b1);
		chk(rd_valid, 1'b0);
		ce = 1'b1;
		reset_with(1'b1);
		chk(build_param_a_enabled, 1'b0);
		read_chk(LVL_MON, 64'h0000_1000_0011_0001);
		summarize();
	end
	initial begin
		#200000;
		err_total++;
		summarize();
	end
endmodule
